// [common/ext_filter_pkg.sv]
package ext_filter_pkg;

   // ----------------------------------------------------------------
   // list geometry
   // ----------------------------------------------------------------
   localparam int MAX_ELEMENTS = 64;
   localparam int ID_W = 29;
   localparam int IDX_W = 6;
   localparam int RAM_AW = 16;
   localparam int WORDS_PER_ELEMENT = 2;

   // ----------------------------------------------------------------
   // element field positions
   // ----------------------------------------------------------------
   localparam int CFG_HI = 31;
   localparam int CFG_LO = 29;
   localparam int TYPE_HI = 31;
   localparam int TYPE_LO = 30;
   localparam int SYNC_BIT = 29;
   localparam int DEST_HI = 10;
   localparam int DEST_LO = 9;
   localparam int OFFS_HI = 5;
   localparam int OFFS_LO = 0;

   // ----------------------------------------------------------------
   // register offsets (byte addresses, word aligned)
   // ----------------------------------------------------------------
   localparam logic [5:0] REG_EXT_FILTER_CONFIG = 6'h00;
   localparam logic [5:0] REG_GLOBAL_AND_MASK = 6'h04;
   localparam logic [5:0] REG_RX_BUF_START = 6'h08;
   localparam logic [5:0] REG_PRIORITY_STATUS = 6'h0c;
   localparam logic [5:0] REG_INTERRUPT_FLAG = 6'h10;
   localparam logic [5:0] REG_RESULT = 6'h14;
   localparam logic [5:0] REG_IRQ_ENABLE = 6'h18;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [28:0] RST_AND_MASK = 29'h1fffffff;
   localparam logic [31:0] RST_ZERO = 32'h00000000;

   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CFG_DISABLE = 3'b000,
      CFG_FIFO0 = 3'b001,
      CFG_FIFO1 = 3'b010,
      CFG_REJECT = 3'b011,
      CFG_PRIO = 3'b100,
      CFG_PRIO_FIFO0 = 3'b101,
      CFG_PRIO_FIFO1 = 3'b110,
      CFG_RXBUF = 3'b111
   } element_config_code_t;

   typedef enum logic [1:0] {
      FT_RANGE = 2'b00,
      FT_DUAL = 2'b01,
      FT_CLASSIC = 2'b10,
      FT_RANGE_NOMASK = 2'b11
   } filter_type_t;

   // outcome of one filter run
   typedef enum logic [2:0] {
      OUT_NONE = 3'b000,
      OUT_FIFO0 = 3'b001,
      OUT_FIFO1 = 3'b010,
      OUT_REJECT = 3'b011,
      OUT_PRIO_ONLY = 3'b100,
      OUT_RXBUF = 3'b101,
      OUT_DEBUG = 3'b110
   } outcome_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RD0 = 3'b001,
      ST_RD1 = 3'b010,
      ST_EVAL = 3'b011,
      ST_DONE = 3'b100
   } walk_state_t;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      element_config_code_t cfg;
      logic [28:0] firstFilterId;
      filter_type_t filterType;
      logic syncMessageBit;
      logic [28:0] secondFilterId;
   } element_t;

   typedef struct packed {
      logic hit;
      outcome_t outcome;
      logic prio;
   } match_t;

   typedef struct packed {
      logic valid;
      outcome_t outcome;
      logic prio;
      logic [5:0] index;
      logic [15:0] bufAddr;
   } result_t;

endpackage : ext_filter_pkg

// [core/ext_filter_match.sv]
`timescale 1ns/1ps
module ext_filter_match
   import ext_filter_pkg::*;
(
   // element and frame
   input wire element_t element,
   input wire logic [28:0] rxId,
   input wire logic [28:0] globalExtAndMask,
   // decision
   output match_t match
);

   // ----------------------------------------------------------------
   // comparison helpers
   // ----------------------------------------------------------------
   function automatic logic inRange(input logic [28:0] id, input logic [28:0] lo,
                                    input logic [28:0] hi);
      inRange = (id >= lo) && (id <= hi);
   endfunction : inRange

   logic [28:0] maskedId;
   logic idHit;

   always_comb begin
      maskedId = (element.filterType == FT_RANGE_NOMASK) ? rxId :
                 (rxId & globalExtAndMask); // [R20] [R12]
      idHit = 1'b0;
      if (element.cfg == CFG_RXBUF) begin
         idHit = (rxId & globalExtAndMask) == element.firstFilterId; // [R7] [R15]
      end else begin
         case (element.filterType)
            FT_RANGE: idHit = inRange(maskedId, element.firstFilterId,
                                      element.secondFilterId); // [R9] [R14]
            FT_DUAL: idHit = (maskedId == element.firstFilterId) ||
                             (maskedId == element.secondFilterId); // [R10]
            FT_CLASSIC: idHit = ((maskedId ^ element.firstFilterId) &
                                 element.secondFilterId) == 29'h0000000; // [R11] [R19]
            FT_RANGE_NOMASK: idHit = inRange(maskedId, element.firstFilterId,
                                             element.secondFilterId); // [R12]
            default: idHit = 1'b0;
         endcase
      end
      match.hit = idHit && (element.cfg != CFG_DISABLE); // [R5]
      match.prio = 1'b0;
      match.outcome = OUT_NONE;
      case (element.cfg)
         CFG_FIFO0: match.outcome = OUT_FIFO0; // [R5]
         CFG_FIFO1: match.outcome = OUT_FIFO1; // [R5]
         CFG_REJECT: match.outcome = OUT_REJECT; // [R5]
         CFG_PRIO: begin
            match.outcome = OUT_PRIO_ONLY; // [R6]
            match.prio = 1'b1;
         end
         CFG_PRIO_FIFO0: begin
            match.outcome = OUT_FIFO0; // [R6]
            match.prio = 1'b1;
         end
         CFG_PRIO_FIFO1: begin
            match.outcome = OUT_FIFO1; // [R6]
            match.prio = 1'b1;
         end
         CFG_RXBUF: begin
            match.outcome = (element.secondFilterId[DEST_HI:DEST_LO] == 2'b00) ?
                            OUT_RXBUF : OUT_DEBUG; // [R16] [R18]
         end
         default: match.outcome = OUT_NONE;
      endcase
   end

endmodule : ext_filter_match

// [core/ext_id_filter.sv]
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// [R1] up to 64 extended elements, each matching 29-bit identifiers
// [R2] element n sits at list start plus two times n words
// [R3] walk enabled elements in order; stop at first match or list end
// [R4] priority configs on match set priority flag and update priority status
// [R5] 000 disabled, 001 FIFO0, 010 FIFO1, 011 reject
// [R6] 100 priority only, 101 priority plus FIFO0, 110 priority plus FIFO1
// [R7] 111 goes to dedicated Rx buffer or debug, filter type ignored
// [R8] word0 bits 31:29 config code, bits 28:0 first identifier
// [R9] type 00 inclusive range between first and second identifiers
// [R10] type 01 accepts identifier equal to either identifier
// [R11] type 10 first identifier is value, second is mask
// [R12] type 11 inclusive range without global AND mask
// [R13] sync bit 29 of word1 carries no meaning
// [R14] configs 001 to 110 use word1 identifier as second identifier
// [R15] Rx buffer filtering compares against first identifier exactly
// [R16] 111 uses second id bits 10:9 to pick buffer or debug A/B/C
// [R17] 111 adds second id bits 5:0 to Rx buffer start address
// [R18] debug message handling not implemented, only dedicated buffer
// [R19] classic type matches where masked bits are all equal
// [R20] types other than 11 apply global AND mask first
module ext_id_filter
   import ext_filter_pkg::*;
#(
   parameter int LIST_MAX = MAX_ELEMENTS
)(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // avalon-mm slave
   input wire logic [5:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   // frame request
   input wire logic frameValid,
   input wire logic [28:0] frameId,
   output logic frameBusy,
   // message ram read port
   output logic ramRead,
   output logic [15:0] ramAddr,
   input wire logic ramReadValid,
   input wire logic [31:0] ramReadData,
   // filter result
   output logic resultValid,
   output logic [2:0] resultOutcome,
   output logic resultPrio,
   output logic [5:0] resultIndex,
   output logic [15:0] resultBufAddr,
   output logic highPriorityFlag
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      walk_state_t st;
      logic [28:0] rxId;
      logic [6:0] idx;
      element_t element;
      logic [15:0] extListStartAddr;
      logic [6:0] listSize;
      logic [28:0] globalExtAndMask;
      logic [15:0] rxBufferStartAddr;
      logic [15:0] priorityStatus;
      logic hpFlag;
      logic hpIrqEnable;
      result_t result;
      logic resultPulse;
      logic ramRead;
      logic [15:0] ramAddr;
      logic [31:0] readData;
      logic ack;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   match_t match;

   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] be);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            m[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      mergeBytes = m;
   endfunction : mergeBytes

   // ----------------------------------------------------------------
   // element matcher
   // ----------------------------------------------------------------
   ext_filter_match u_match (
      .element(s_r.element),
      .rxId(s_r.rxId),
      .globalExtAndMask(s_r.globalExtAndMask),
      .match(match)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] cfgWord;
      logic [31:0] w;
      logic [6:0] lim;
      logic hpClear;
      cfgWord = {9'h000, s_r.listSize, s_r.extListStartAddr};
      w = 32'h00000000;
      lim = 7'h00;
      hpClear = 1'b0;
      s_nxt = s_r;
      s_nxt.resultPulse = 1'b0;
      s_nxt.ramRead = 1'b0;
      s_nxt.ack = 1'b0;
      s_nxt.readData = 32'h00000000;
      lim = (s_r.listSize > LIST_MAX[6:0]) ? LIST_MAX[6:0] : s_r.listSize; // [R1]

      // register access: one wait cycle; a write lands with the answer
      if ((avsRead && !s_r.ack) || avsWrite) begin
         s_nxt.ack = !s_r.ack;
         if (avsRead) begin
            case (avsAddress)
               REG_EXT_FILTER_CONFIG: s_nxt.readData = cfgWord;
               REG_GLOBAL_AND_MASK: s_nxt.readData = {3'h0, s_r.globalExtAndMask};
               REG_RX_BUF_START: s_nxt.readData = {16'h0000, s_r.rxBufferStartAddr};
               REG_PRIORITY_STATUS: s_nxt.readData = {16'h0000, s_r.priorityStatus};
               REG_INTERRUPT_FLAG: s_nxt.readData = {31'h00000000, s_r.hpFlag};
               REG_RESULT: s_nxt.readData = {s_r.result.valid, 5'h00, s_r.result.bufAddr,
                                             s_r.result.index, s_r.result.prio,
                                             s_r.result.outcome};
               REG_IRQ_ENABLE: s_nxt.readData = {31'h00000000, s_r.hpIrqEnable};
               default: s_nxt.readData = 32'h00000000;
            endcase
         end else if (s_r.ack) begin
            case (avsAddress)
               REG_EXT_FILTER_CONFIG: begin
                  w = mergeBytes(cfgWord, avsWriteData, avsByteEnable);
                  s_nxt.extListStartAddr = w[15:0];
                  s_nxt.listSize = w[22:16];
               end
               REG_GLOBAL_AND_MASK: begin
                  w = mergeBytes({3'h0, s_r.globalExtAndMask}, avsWriteData, avsByteEnable);
                  s_nxt.globalExtAndMask = w[28:0];
               end
               REG_RX_BUF_START: begin
                  w = mergeBytes({16'h0000, s_r.rxBufferStartAddr}, avsWriteData,
                                 avsByteEnable);
                  s_nxt.rxBufferStartAddr = w[15:0];
               end
               REG_INTERRUPT_FLAG: hpClear = avsByteEnable[0] && avsWriteData[0];
               REG_IRQ_ENABLE: begin
                  if (avsByteEnable[0]) begin
                     s_nxt.hpIrqEnable = avsWriteData[0];
                  end
               end
               default: w = 32'h00000000;
            endcase
         end
      end
      if (hpClear) begin
         s_nxt.hpFlag = 1'b0;
      end

      // filter walk
      case (s_r.st)
         ST_IDLE: begin
            if (frameValid) begin
               s_nxt.rxId = frameId;
               s_nxt.idx = 7'h00;
               s_nxt.st = (lim == 7'h00) ? ST_DONE : ST_RD0;
               s_nxt.ramRead = (lim != 7'h00);
               s_nxt.ramAddr = s_r.extListStartAddr; // [R2]
               s_nxt.result = '0;
            end
         end
         ST_RD0: begin
            s_nxt.ramRead = !ramReadValid;
            if (ramReadValid) begin
               s_nxt.element.cfg = element_config_code_t'(ramReadData[CFG_HI:CFG_LO]); // [R8]
               s_nxt.element.firstFilterId = ramReadData[28:0]; // [R8]
               if (ramReadData[CFG_HI:CFG_LO] == CFG_DISABLE) begin
                  // disabled element: skip the second word
                  if (s_r.idx + 7'h01 >= lim) begin
                     s_nxt.st = ST_DONE;
                  end else begin
                     s_nxt.idx = s_r.idx + 7'h01;
                     s_nxt.ramAddr = s_r.ramAddr + 16'h0002; // [R2]
                     s_nxt.ramRead = 1'b1;
                  end
               end else begin
                  s_nxt.st = ST_RD1;
                  s_nxt.ramAddr = s_r.ramAddr + 16'h0001;
                  s_nxt.ramRead = 1'b1;
               end
            end
         end
         ST_RD1: begin
            s_nxt.ramRead = !ramReadValid;
            if (ramReadValid) begin
               s_nxt.element.filterType = filter_type_t'(ramReadData[TYPE_HI:TYPE_LO]);
               s_nxt.element.syncMessageBit = 1'b0; // [R13]
               s_nxt.element.secondFilterId = ramReadData[28:0]; // [R14]
               s_nxt.st = ST_EVAL;
            end
         end
         ST_EVAL: begin
            if (match.hit) begin
               s_nxt.result.valid = 1'b1; // [R3]
               s_nxt.result.outcome = match.outcome;
               s_nxt.result.prio = match.prio;
               s_nxt.result.index = s_r.idx[5:0];
               s_nxt.result.bufAddr = (match.outcome == OUT_RXBUF) ?
                  s_r.rxBufferStartAddr +
                  {10'h000, s_r.element.secondFilterId[OFFS_HI:OFFS_LO]} :
                  16'h0000; // [R17]
               if (match.prio) begin
                  s_nxt.hpFlag = 1'b1; // [R4]
                  s_nxt.priorityStatus = {8'h00, 1'b1, s_r.idx}; // [R4]
               end
               s_nxt.st = ST_DONE;
            end else if (s_r.idx + 7'h01 >= lim) begin
               s_nxt.st = ST_DONE; // [R3]
            end else begin
               s_nxt.idx = s_r.idx + 7'h01;
               s_nxt.ramAddr = s_r.ramAddr + 16'h0001; // [R2]
               s_nxt.ramRead = 1'b1;
               s_nxt.st = ST_RD0;
            end
         end
         ST_DONE: begin
            s_nxt.resultPulse = 1'b1;
            s_nxt.st = ST_IDLE;
         end
         default: s_nxt.st = ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
         s_r.globalExtAndMask <= RST_AND_MASK;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign avsReadData = s_r.readData;
   assign avsWaitRequest = !s_r.ack;
   assign frameBusy = (s_r.st != ST_IDLE);
   assign ramRead = s_r.ramRead;
   assign ramAddr = s_r.ramAddr;
   assign resultValid = s_r.resultPulse;
   assign resultOutcome = s_r.result.outcome;
   assign resultPrio = s_r.result.prio;
   assign resultIndex = s_r.result.index;
   assign resultBufAddr = s_r.result.bufAddr;
   assign highPriorityFlag = s_r.hpFlag && s_r.hpIrqEnable;

endmodule : ext_id_filter

// [test/msg_ram_model.sv]
`timescale 1ns/1ps
module msg_ram_model (
   // clock
   input wire logic clk,
   // read port
   input wire logic ramRead,
   input wire logic [15:0] ramAddr,
   output logic ramReadValid,
   output logic [31:0] ramReadData
);
   // ------------------------------------------------------------
   // filter list storage, written by the bench
   // ------------------------------------------------------------
   logic [31:0] mem [0:255];
   int lat = 0;
   int cnt = 0;

   initial begin
      ramReadValid = 1'b0;
      ramReadData = 32'h0;
      for (int i = 0; i < 256; i++) mem[i] = 32'h0;
   end

   // answer after lat cycles; stale data is inverted once released
   always @(posedge clk) begin
      if (ramReadValid) begin
         ramReadValid <= 1'b0;
         ramReadData <= ~ramReadData;
      end else if (ramRead) begin
         if (cnt >= lat) begin
            ramReadValid <= 1'b1;
            ramReadData <= mem[ramAddr[7:0]];
            cnt <= 0;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule : msg_ram_model

// [test/ext_id_filter_monitor.sv]
`timescale 1ns/1ps
module ext_id_filter_monitor
   import ext_filter_pkg::*;
#(
   parameter int LIST_MAX = MAX_ELEMENTS
)(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // bus
   input wire logic [5:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic avsWaitRequest,
   // frame and ram
   input wire logic frameValid,
   input wire logic frameBusy,
   input wire logic ramRead,
   input wire logic [15:0] ramAddr,
   input wire logic ramReadValid,
   // result
   input wire logic resultValid,
   input wire logic [2:0] resultOutcome,
   input wire logic resultPrio,
   input wire logic highPriorityFlag
);
   // ------------------------------------------------------------
   // shadow of list config and irq enable
   // ------------------------------------------------------------
   logic [31:0] listCfg_r;
   logic irqEn_r;
   logic [15:0] relAddr;
   logic [7:0] listSize;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         listCfg_r <= 32'h0;
         irqEn_r <= 1'b0;
      end else if (avsWrite && !avsWaitRequest) begin
         if (avsAddress == REG_EXT_FILTER_CONFIG) listCfg_r <= avsWriteData;
         if (avsAddress == REG_IRQ_ENABLE) irqEn_r <= avsWriteData[0];
      end
   end
   assign relAddr = ramAddr - listCfg_r[15:0];
   assign listSize = (listCfg_r[22:16] > LIST_MAX) ? 8'(LIST_MAX) : {1'b0, listCfg_r[22:16]};

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   bus_answer_a: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
      else $error("bus answer late");
   wait_pulse_a: assert property (!avsWaitRequest |=> avsWaitRequest)
      else $error("waitrequest low too long");
   start_addr_a: assert property (frameValid && !frameBusy && listSize != 8'h0 |->
      ##[1:2] (ramRead && ramAddr == listCfg_r[15:0])) else $error("walk start address");
   addr_window_a: assert property (ramRead |-> relAddr < {listSize, 1'b0})
      else $error("ram address outside list");
   ram_hold_a: assert property (ramRead && !ramReadValid |=> ramRead && $stable(ramAddr))
      else $error("ram request dropped");
   result_bound_a: assert property (frameValid && !frameBusy |-> ##[1:1000] resultValid)
      else $error("walk did not finish");
   result_pulse_a: assert property (resultValid |=> !resultValid)
      else $error("result pulse too long");
   no_prio_a: assert property (resultValid && resultOutcome inside {3'h0, 3'h3}
      |-> !resultPrio) else $error("priority on reject or none");
   prio_flag_a: assert property (resultValid && resultPrio && irqEn_r |-> highPriorityFlag)
      else $error("priority flag not set");
   flag_en_a: assert property (!irqEn_r |-> !highPriorityFlag)
      else $error("flag without enable");

   cover property (resultValid && resultPrio);
   cover property (resultValid && resultOutcome == 3'h5);
   cover property (avsRead && !avsWaitRequest);
endmodule : ext_id_filter_monitor

// [test/ext_id_filter_tb_top.sv]
`timescale 1ns/1ps
module ext_id_filter_tb_top import ext_filter_pkg::*;;
   localparam logic [15:0] LS = 16'h0010;
   localparam logic [15:0] RB = 16'h0400;
   logic clk, reset_n, avsRead, avsWrite, avsWaitRequest, frameValid, frameBusy;
   logic ramRead, ramReadValid, resultValid, resultPrio, highPriorityFlag;
   logic [5:0] avsAddress, resultIndex;
   logic [31:0] avsWriteData, avsReadData, ramReadData;
   logic [3:0] avsByteEnable;
   logic [28:0] frameId;
   logic [15:0] ramAddr, resultBufAddr;
   logic [2:0] resultOutcome;
   int n_errors = 0;
   int total_checks = 0;

   ext_id_filter i_ext_id_filter (.clk(clk), .reset_n(reset_n), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
      .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
      .avsWaitRequest(avsWaitRequest), .frameValid(frameValid), .frameId(frameId),
      .frameBusy(frameBusy), .ramRead(ramRead), .ramAddr(ramAddr),
      .ramReadValid(ramReadValid), .ramReadData(ramReadData), .resultValid(resultValid),
      .resultOutcome(resultOutcome), .resultPrio(resultPrio), .resultIndex(resultIndex),
      .resultBufAddr(resultBufAddr), .highPriorityFlag(highPriorityFlag));
   msg_ram_model i_msg_ram_model (.clk(clk), .ramRead(ramRead), .ramAddr(ramAddr),
      .ramReadValid(ramReadValid), .ramReadData(ramReadData));

   always #4 clk = ~clk;

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic give_verdict();
      if (n_errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      n = 0;
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= !wr;
      avsWriteData <= wd;
      @(posedge clk);
      while (avsWaitRequest !== 1'b0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      rd = avsReadData;
      if (n >= 100) n_errors++;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] rd;
      bus(1'b1, a, d, rd);
   endtask : wr_reg

   task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input string msg);
      logic [31:0] rd;
      bus(1'b0, a, 32'h0, rd);
      chk(rd, exp, msg);
   endtask : rd_chk

   task automatic put_el(input int n, input logic [2:0] cf, input logic [28:0] id1,
                         input logic [1:0] ft, input logic sy, input logic [28:0] id2);
      i_msg_ram_model.mem[8'(LS + 2 * n)] = {cf, id1};
      i_msg_ram_model.mem[8'(LS + 2 * n + 1)] = {ft, sy, id2};
   endtask : put_el

   task automatic frame(input logic [28:0] id, input logic [2:0] oc, input logic pr,
                        input logic [5:0] ix, input logic [15:0] ba);
      int n;
      n = 0;
      while (frameBusy !== 1'b0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      frameValid <= 1'b1;
      frameId <= id;
      @(posedge clk);
      frameValid <= 1'b0;
      while (resultValid !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, resultValid}, 32'h1, "result pulse");
      chk({29'h0, resultOutcome}, {29'h0, oc}, "outcome");
      if (oc != OUT_NONE) chk({25'h0, resultPrio, resultIndex}, {25'h0, pr, ix}, "index");
      if (oc == OUT_RXBUF) chk({16'h0, resultBufAddr}, {16'h0, ba}, "buffer");
      @(posedge clk);
   endtask : frame

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      {avsRead, avsWrite, frameValid} = 3'h0;
      avsAddress = 6'h0;
      avsWriteData = 32'h0;
      avsByteEnable = 4'hf;
      frameId = 29'h0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd_chk(REG_GLOBAL_AND_MASK, 32'h1fffffff, "mask reset");
      rd_chk(REG_EXT_FILTER_CONFIG, 32'h0, "config reset");
      rd_chk(6'h1c, 32'h0, "unmapped read");
      put_el(0, 3'h0, 29'h0, 2'h0, 1'b0, 29'h1fffffff);
      put_el(1, 3'h1, 29'h100, 2'h0, 1'b0, 29'h1ff);
      put_el(2, 3'h2, 29'h300, 2'h1, 1'b1, 29'h3ff);
      put_el(3, 3'h3, 29'ha00, 2'h2, 1'b0, 29'h1fffff00);
      put_el(4, 3'h4, 29'h12345000, 2'h3, 1'b0, 29'h12345fff);
      put_el(5, 3'h5, 29'h5000, 2'h1, 1'b0, 29'h5000);
      put_el(6, 3'h6, 29'h6000, 2'h1, 1'b0, 29'h6000);
      put_el(7, 3'h7, 29'h7000, 2'h1, 1'b0, 29'h5);
      put_el(8, 3'h7, 29'h8000, 2'h0, 1'b0, 29'h200);
      put_el(9, 3'h2, 29'h0, 2'h0, 1'b0, 29'h1fffffff);
      put_el(63, 3'h1, 29'h3f3f, 2'h1, 1'b0, 29'h3f3f);
      put_el(64, 3'h1, 29'h0, 2'h0, 1'b0, 29'h1fffffff);
      wr_reg(REG_EXT_FILTER_CONFIG, {9'h0, 7'd10, LS});
      wr_reg(REG_GLOBAL_AND_MASK, 32'h0fffffff);
      wr_reg(REG_RX_BUF_START, {16'h0, RB});
      wr_reg(REG_IRQ_ENABLE, 32'h1);
      frame(29'h10000150, OUT_FIFO0, 1'b0, 6'd1, 16'h0);
      frame(29'h1ff, OUT_FIFO0, 1'b0, 6'd1, 16'h0);
      frame(29'h200, OUT_FIFO1, 1'b0, 6'd9, 16'h0);
      frame(29'h3ff, OUT_FIFO1, 1'b0, 6'd2, 16'h0);
      frame(29'h301, OUT_FIFO1, 1'b0, 6'd9, 16'h0);
      frame(29'ha5a, OUT_REJECT, 1'b0, 6'd3, 16'h0);
      frame(29'hb00, OUT_FIFO1, 1'b0, 6'd9, 16'h0);
      frame(29'h12345100, OUT_PRIO_ONLY, 1'b1, 6'd4, 16'h0);
      chk({31'h0, highPriorityFlag}, 32'h1, "flag pin");
      rd_chk(REG_PRIORITY_STATUS, 32'h84, "priority status");
      rd_chk(REG_INTERRUPT_FLAG, 32'h1, "flag set");
      wr_reg(REG_INTERRUPT_FLAG, 32'h1);
      rd_chk(REG_INTERRUPT_FLAG, 32'h0, "flag clear");
      chk({31'h0, highPriorityFlag}, 32'h0, "flag pin clear");
      frame(29'h5000, OUT_FIFO0, 1'b1, 6'd5, 16'h0);
      frame(29'h6000, OUT_FIFO1, 1'b1, 6'd6, 16'h0);
      i_msg_ram_model.lat = 3;
      frame(29'h7000, OUT_RXBUF, 1'b0, 6'd7, RB + 16'h5);
      rd_chk(REG_RESULT, 32'h80101475, "result word");
      frame(29'h5, OUT_FIFO1, 1'b0, 6'd9, 16'h0);
      frame(29'h8000, OUT_DEBUG, 1'b0, 6'd8, 16'h0);
      wr_reg(REG_EXT_FILTER_CONFIG, {9'h0, 7'd9, LS});
      frame(29'h1234, OUT_NONE, 1'b0, 6'd0, 16'h0);
      i_msg_ram_model.lat = 0;
      put_el(9, 3'h0, 29'h0, 2'h0, 1'b0, 29'h1fffffff);
      wr_reg(REG_EXT_FILTER_CONFIG, {9'h0, 7'd127, LS});
      frame(29'h3f3f, OUT_FIFO0, 1'b0, 6'd63, 16'h0);
      frame(29'h1234, OUT_NONE, 1'b0, 6'd0, 16'h0);
      give_verdict();
   end

   initial begin
      repeat (50000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
endmodule : ext_id_filter_tb_top

bind ext_id_filter ext_id_filter_monitor #(.LIST_MAX(LIST_MAX)) i_ext_id_filter_monitor (
   .clk(clk), .reset_n(reset_n), .avsAddress(avsAddress), .avsRead(avsRead),
   .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsWaitRequest(avsWaitRequest),
   .frameValid(frameValid), .frameBusy(frameBusy), .ramRead(ramRead), .ramAddr(ramAddr),
   .ramReadValid(ramReadValid), .resultValid(resultValid), .resultOutcome(resultOutcome),
   .resultPrio(resultPrio), .highPriorityFlag(highPriorityFlag));
